// ===== shared/csi2c_pkg.sv
// constants, state type and bus codes shared by the register-access slave
// Function
// - a read sends the register selected by the pointer, then awaits master ack
// - master ack on a read byte advances the pointer and sends the next register
// - master nack on a read returns to idle without moving the pointer
// - the pointer itself is never readable; reads always return register contents
// - reads past the valid range keep sending contents until nack, start or stop
// - a stop ending a read sets the pointer back to the status location
// - writes to an invalid location are dropped but still acknowledged
// - first write byte after the address is the pointer, loaded and acknowledged
// - after the pointer byte accept stop, restart or data; stop clears the pointer
// - each data byte is stored at the pointer, acknowledged, pointer incremented
// - a repeated start is handled exactly like a first start
// - pointer byte 0xBF is a reset command that reloads all default values
// - no acknowledge to any transfer during the roughly 2 ms default upload
// - the general call address is acknowledged and its command byte received
// - general call command 0x06 performs a full reset with the upload window
// - any other general call command byte is not acknowledged
// - stop is a rising data line while the clock line is high
// - respond to address byte 0x90 for writes and 0x91 for reads
package csi2c_pkg;

    // bus codes
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hBF;
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // idle levels of the bus lines after reset
    localparam logic SCL_IDLE = 1'b1;
    localparam logic SDA_IDLE = 1'b1;

    // default upload window
    localparam int UPLOAD_TIME_US = 2000;
    localparam int CLK_FREQ_MHZ = 50;
    localparam int UPLOAD_CYCLES = UPLOAD_TIME_US * CLK_FREQ_MHZ;
    localparam int UPLOAD_CNT_W = 17;

    // slave protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_GCMD,
        ST_ACK_PEND,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_RACK_NEXT,
        ST_UPLOAD
    } csi2c_state_type;

endpackage : csi2c_pkg

// ===== rtl/csi2c_cond_det.sv
// bus condition and clock edge detector for the register-access slave
`timescale 1ns/1ps
module csi2c_cond_det
    import csi2c_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // events
    output logic start_det,
    output logic stop_det,
    output logic scl_rise,
    output logic scl_fall
);

    typedef struct packed {
        logic scl;
        logic sda;
    } csi2c_det_type;

    csi2c_det_type cur;
    csi2c_det_type next_cur;

    // previous line levels
    always_comb begin
        next_cur = cur;
        next_cur.scl = scl_in;
        next_cur.sda = sda_in;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur.scl <= SCL_IDLE;
            cur.sda <= SDA_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // data edges while the clock stays high mark start and stop
    assign start_det = cur.scl && scl_in && cur.sda && !sda_in;
    assign stop_det = cur.scl && scl_in && !cur.sda && sda_in;
    assign scl_rise = !cur.scl && scl_in;
    assign scl_fall = cur.scl && !scl_in;

endmodule : csi2c_cond_det

// ===== rtl/csi2c_slave.sv
// two-wire slave giving a bus master access to the internal register set
`timescale 1ns/1ps
module csi2c_slave
    import csi2c_pkg::*;
#(
    parameter int UPLOAD_LEN = UPLOAD_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // bus pins, sda is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // internal register file access
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_valid,
    // default reload
    output logic defaults_load,
    output logic upload_busy
);

    typedef struct packed {
        csi2c_state_type state;
        csi2c_state_type after;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic drive;
        logic ack_ok;
        logic addressed;
        logic we;
        logic [7:0] wdata;
        logic load;
        logic [UPLOAD_CNT_W-1:0] cnt;
    } csi2c_slv_type;

    localparam logic [UPLOAD_CNT_W-1:0] UPLOAD_LAST = UPLOAD_CNT_W'(UPLOAD_LEN - 1);

    csi2c_slv_type cur;
    csi2c_slv_type next_cur;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] rx_byte;

    ////////////////////////////////////////////////////////////////////////
    // line conditions

    csi2c_cond_det u_det (
        .mclk(mclk),
        .rst_b(rst_b),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_det(start_det),
        .stop_det(stop_det),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall)
    );

    // byte as it completes on the eighth rising clock
    assign rx_byte = {cur.shreg[6:0], sda_in};

    ////////////////////////////////////////////////////////////////////////
    // protocol state machine

    always_comb begin
        next_cur = cur;
        next_cur.we = 1'b0;
        next_cur.load = 1'b0;
        if (cur.state == ST_UPLOAD) begin
            // bus ignored entirely while defaults reload
            next_cur.drive = 1'b0;
            next_cur.cnt = cur.cnt + 1'b1;
            if (cur.cnt == UPLOAD_LAST) begin
                next_cur.state = ST_IDLE;
                next_cur.ptr = PTR_RESET;
                next_cur.addressed = 1'b0;
            end
        end else if (start_det) begin
            // restart behaves like the first start
            next_cur.state = ST_ADDR;
            next_cur.bitcnt = 3'h0;
            next_cur.drive = 1'b0;
        end else if (stop_det) begin
            next_cur.state = ST_IDLE;
            next_cur.drive = 1'b0;
            if (cur.addressed) begin
                // pointer back to status after reads and after writes
                next_cur.ptr = PTR_RESET;
            end
            next_cur.addressed = 1'b0;
        end else begin
            case (cur.state)
                ST_IDLE: begin
                    next_cur.drive = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA, ST_GCMD: begin
                    if (scl_rise) begin
                        next_cur.shreg = rx_byte;
                        next_cur.bitcnt = cur.bitcnt + 3'h1;
                        if (cur.bitcnt == 3'h7) begin
                            next_cur.state = ST_ACK_PEND;
                            next_cur.ack_ok = 1'b1;
                            case (cur.state)
                                ST_ADDR: begin
                                    if (rx_byte[7:1] == SLAVE_ADDR) begin
                                        next_cur.addressed = 1'b1;
                                        next_cur.after = rx_byte[0] ? ST_TX : ST_PTR;
                                    end else if (rx_byte == {GC_ADDR, 1'b0}) begin
                                        next_cur.after = ST_GCMD;
                                    end else begin
                                        next_cur.state = ST_IDLE;
                                        next_cur.ack_ok = 1'b0;
                                    end
                                end
                                ST_PTR: begin
                                    next_cur.ptr = rx_byte;
                                    if (rx_byte == CMD_SOFT_RESET) begin
                                        next_cur.after = ST_UPLOAD;
                                    end else begin
                                        next_cur.after = ST_WDATA;
                                    end
                                end
                                ST_WDATA: begin
                                    // invalid locations are dropped yet acked
                                    next_cur.we = reg_valid;
                                    next_cur.wdata = rx_byte;
                                    next_cur.ptr = cur.ptr + 8'h01;
                                    next_cur.after = ST_WDATA;
                                end
                                default: begin
                                    if (rx_byte == GC_CMD_RESET) begin
                                        next_cur.after = ST_UPLOAD;
                                    end else begin
                                        next_cur.state = ST_IDLE;
                                        next_cur.ack_ok = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK_PEND: begin
                    // pull data low through the ninth clock
                    if (scl_fall) begin
                        next_cur.drive = cur.ack_ok;
                        next_cur.state = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_cur.drive = 1'b0;
                        next_cur.bitcnt = 3'h0;
                        next_cur.state = cur.after;
                        if (cur.after == ST_TX) begin
                            // register contents, never the pointer itself
                            next_cur.shreg = reg_rdata;
                            next_cur.drive = !reg_rdata[7];
                        end else if (cur.after == ST_UPLOAD) begin
                            next_cur.load = 1'b1;
                            next_cur.cnt = '0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        next_cur.bitcnt = cur.bitcnt + 3'h1;
                        if (cur.bitcnt == 3'h7) begin
                            // release for the master's acknowledge
                            next_cur.drive = 1'b0;
                            next_cur.state = ST_RACK;
                        end else begin
                            next_cur.shreg = {cur.shreg[6:0], 1'b0};
                            next_cur.drive = !cur.shreg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            next_cur.state = ST_IDLE;
                        end else begin
                            // runs on past the map until nack, start or stop
                            next_cur.ptr = cur.ptr + 8'h01;
                            next_cur.state = ST_RACK_NEXT;
                        end
                    end
                end
                ST_RACK_NEXT: begin
                    // reg_rdata has had half a bit time to follow the new pointer
                    if (scl_fall) begin
                        next_cur.shreg = reg_rdata;
                        next_cur.drive = !reg_rdata[7];
                        next_cur.bitcnt = 3'h0;
                        next_cur.state = ST_TX;
                    end
                end
                default: begin
                    next_cur.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur.state <= ST_IDLE;
            cur.after <= ST_IDLE;
            cur.bitcnt <= 3'h0;
            cur.shreg <= 8'h00;
            cur.ptr <= PTR_RESET;
            cur.drive <= 1'b0;
            cur.ack_ok <= 1'b0;
            cur.addressed <= 1'b0;
            cur.we <= 1'b0;
            cur.wdata <= 8'h00;
            cur.load <= 1'b0;
            cur.cnt <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = cur.drive;
    assign reg_addr = cur.ptr;
    assign reg_wdata = cur.wdata;
    assign reg_we = cur.we;
    assign defaults_load = cur.load;
    assign upload_busy = (cur.state == ST_UPLOAD);

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_upload_silent: assert property (@(posedge mclk) disable iff (!rst_b)
        upload_busy |-> !sda_oe)
        else $error("sda driven during upload");

    a_upload_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(upload_busy) |-> upload_busy [*8])
        else $error("upload window too short");

    a_load_enters: assert property (@(posedge mclk) disable iff (!rst_b)
        defaults_load |-> upload_busy && $past(cur.state) == ST_ACK)
        else $error("default load outside upload entry");

    a_stop_clears: assert property (@(posedge mclk) disable iff (!rst_b)
        (stop_det && cur.addressed && !upload_busy) |=> reg_addr == PTR_RESET)
        else $error("pointer not reset on stop");

    a_nack_keeps: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_RACK && scl_rise && sda_in && !start_det && !stop_det)
        |=> cur.state == ST_IDLE && reg_addr == $past(reg_addr))
        else $error("nack moved pointer or stayed busy");

    a_ack_advance: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_RACK && scl_rise && !sda_in && !start_det && !stop_det)
        |=> reg_addr == 8'($past(reg_addr) + 8'h01))
        else $error("pointer not advanced on ack");

    a_restart_addr: assert property (@(posedge mclk) disable iff (!rst_b)
        (start_det && !upload_busy) |=> cur.state == ST_ADDR && !sda_oe)
        else $error("start not handled");

    a_write_store: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_WDATA && scl_rise && cur.bitcnt == 3'h7 && !start_det && !stop_det)
        |=> reg_we == $past(reg_valid) && reg_wdata == $past(rx_byte))
        else $error("write byte not stored");

    a_read_msb: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_ACK && scl_fall && cur.after == ST_TX && !start_det && !stop_det)
        |=> sda_oe == !$past(reg_rdata[7]))
        else $error("first read bit wrong");

    // own address byte is claimed and acknowledged
    a_addr_match: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_ADDR && scl_rise && cur.bitcnt == 3'h7 && !start_det && !stop_det
        && rx_byte[7:1] == SLAVE_ADDR) |=> cur.state == ST_ACK_PEND && cur.ack_ok)
        else $error("own address not claimed");

    // all-zero write address leads into command reception
    a_gc_accept: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_ADDR && scl_rise && cur.bitcnt == 3'h7 && !start_det && !stop_det
        && rx_byte == {GC_ADDR, 1'b0}) |=> cur.ack_ok && cur.after == ST_GCMD)
        else $error("general call not accepted");

    // any other command byte leaves the bus alone
    a_gc_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_GCMD && scl_rise && cur.bitcnt == 3'h7 && !start_det && !stop_det
        && rx_byte != GC_CMD_RESET) |=> cur.state == ST_IDLE && !sda_oe)
        else $error("foreign command acknowledged");

    // a byte for an invalid location is acked but never stored
    a_bad_write_drop: assert property (@(posedge mclk) disable iff (!rst_b)
        (cur.state == ST_WDATA && scl_rise && cur.bitcnt == 3'h7 && !start_det && !stop_det
        && !reg_valid) |=> !reg_we && cur.state == ST_ACK_PEND && cur.ack_ok)
        else $error("invalid write not dropped");

    // end of the reload window frees the bus with the pointer at status
    a_upload_ends: assert property (@(posedge mclk) disable iff (!rst_b)
        (upload_busy && cur.cnt == UPLOAD_LAST) |=> !upload_busy && reg_addr == PTR_RESET)
        else $error("upload did not end cleanly");

endmodule : csi2c_slave

// ===== tb/csi2c_master_model.sv
// bus master model for the register-access slave
`timescale 1ns/1ps
module csi2c_master_model (
    // clock
    input wire logic mclk,
    // bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda_bus
);
    // idle bus, both lines released high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // wait n clock cycles
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // one bit; sda only moves while scl is low
    task automatic bit_xfer(input logic b, output logic r);
        sda_drv <= b;
        tick(3);
        scl <= 1'b1;
        tick(3);
        #1 r = sda_bus;
        tick(1);
        scl <= 1'b0;
        tick(2);
    endtask : bit_xfer
    // start, also used as repeated start
    task automatic start_cond();
        sda_drv <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b0;
        tick(3);
    endtask : start_cond
    // stop: sda rises while scl high
    task automatic stop_cond();
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_drv <= 1'b1;
        tick(3);
    endtask : stop_cond
    // eight bits msb first, then the ninth bit sent as nine
    task automatic byte_xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
            output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(nine, r);
        ack = ~r;
    endtask : byte_xfer
endmodule : csi2c_master_model

// ===== tb/csi2c_slave_tb_top.sv
// self-checking bench for the register-access slave
`timescale 1ns/1ps
module csi2c_slave_tb_top;
    import csi2c_pkg::*;
    localparam int UPLOAD_SIM = 400;
    localparam int LIMIT = 20000;
    // clock, reset, bus
    logic mclk;
    logic rst_b;
    logic scl;
    logic sda_drv;
    logic sda_out;
    logic sda_oe;
    wire sda_bus = sda_drv & ~(sda_oe & ~sda_out);
    // register side
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_we;
    logic [7:0] reg_rdata;
    logic reg_valid;
    logic defaults_load;
    logic upload_busy;
    logic [7:0] regs [256];
    logic [7:0] prev_addr;
    int we_cnt;
    int load_cnt;
    int failures;
    int checks;
    int cycles;
    ////////////////////////////////////////////////////////////////
    csi2c_slave #(.UPLOAD_LEN(UPLOAD_SIM)) u_csi2c_slave (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_rdata(reg_rdata), .reg_valid(reg_valid), .defaults_load(defaults_load),
        .upload_busy(upload_busy));
    csi2c_master_model u_csi2c_master_model (
        .mclk(mclk), .scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));
    // clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // register file; previous pointer kept since it may move with the write pulse
    always @(posedge mclk) begin
        prev_addr <= reg_addr;
        reg_rdata <= regs[reg_addr];
        reg_valid <= reg_addr < 8'h10;
        if (reg_we) begin
            regs[prev_addr] <= reg_wdata;
            we_cnt <= we_cnt + 1;
        end
        if (defaults_load) load_cnt <= load_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // write-direction byte, returns slave ack
    task automatic send(input logic [7:0] d, output logic [7:0] a);
        logic [7:0] q;
        logic k;
        u_csi2c_master_model.byte_xfer(d, 1'b1, q, k);
        a = {7'h00, k};
    endtask : send
    // read byte, master acks when mack is high
    task automatic recv(input logic mack, output logic [7:0] q);
        logic k;
        u_csi2c_master_model.byte_xfer(8'hFF, ~mack, q, k);
    endtask : recv
    // bounded wait for the upload window to close
    task automatic wait_idle();
        for (int k = 0; k < 1000 && upload_busy !== 1'b0; k++) @(posedge mclk);
        chk({7'h00, upload_busy}, 8'h00);
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////
    task automatic t_write_read();
        logic [7:0] a;
        logic [7:0] q;
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        chk(a, 8'h01);
        send(8'h03, a);
        chk(a, 8'h01);
        send(8'hA5, a);
        send(8'h5A, a);
        chk(a, 8'h01);
        u_csi2c_master_model.stop_cond();
        chk(regs[8'h03], 8'hA5);
        chk(regs[8'h04], 8'h5A);
        chk(reg_addr, 8'h00);
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        send(8'h03, a);
        u_csi2c_master_model.start_cond();
        send(8'h91, a);
        chk(a, 8'h01);
        recv(1'b1, q);
        chk(q, 8'hA5);
        recv(1'b0, q);
        chk(q, 8'h5A);
        chk(reg_addr, 8'h04);
        u_csi2c_master_model.stop_cond();
        chk(reg_addr, 8'h00);
        $display("test write_read done");
    endtask : t_write_read
    // invalid write, foreign address, read across the pointer wrap
    task automatic t_edges();
        logic [7:0] a;
        logic [7:0] q;
        int n;
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        send(8'h20, a);
        n = we_cnt;
        send(8'h77, a);
        chk(a, 8'h01);
        chk(8'(we_cnt - n), 8'h00);
        u_csi2c_master_model.start_cond();
        send(8'h92, a);
        chk(a, 8'h00);
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        send(8'hFF, a);
        u_csi2c_master_model.start_cond();
        send(8'h91, a);
        recv(1'b1, q);
        chk(q, 8'h3C);
        recv(1'b1, q);
        chk(q, 8'hC3);
        recv(1'b0, q);
        chk(q, 8'hC2);
        u_csi2c_master_model.stop_cond();
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        send(8'h07, a);
        chk(reg_addr, 8'h07);
        u_csi2c_master_model.stop_cond();
        chk(reg_addr, 8'h00);
        $display("test edges done");
    endtask : t_edges
    task automatic t_general_call();
        logic [7:0] a;
        int n;
        u_csi2c_master_model.start_cond();
        send(8'h00, a);
        chk(a, 8'h01);
        send(8'h55, a);
        chk(a, 8'h00);
        u_csi2c_master_model.stop_cond();
        n = load_cnt;
        u_csi2c_master_model.start_cond();
        send(8'h00, a);
        send(8'h06, a);
        chk(a, 8'h01);
        u_csi2c_master_model.stop_cond();
        chk(8'(load_cnt - n), 8'h01);
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        chk(a, 8'h00);
        u_csi2c_master_model.stop_cond();
        wait_idle();
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        chk(a, 8'h01);
        u_csi2c_master_model.stop_cond();
        $display("test general_call done");
    endtask : t_general_call
    task automatic t_soft_reset();
        logic [7:0] a;
        int n;
        n = load_cnt;
        u_csi2c_master_model.start_cond();
        send(8'h90, a);
        send(8'hBF, a);
        chk(a, 8'h01);
        u_csi2c_master_model.stop_cond();
        chk(8'(load_cnt - n), 8'h01);
        chk({7'h00, upload_busy}, 8'h01);
        wait_idle();
        chk(reg_addr, 8'h00);
        $display("test soft_reset done");
    endtask : t_soft_reset
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'hC3;
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_write_read();
        t_edges();
        t_general_call();
        t_soft_reset();
        print_verdict();
    end
endmodule : csi2c_slave_tb_top
